// ### include/core_tick_irq_cfg.svh
// Constants for the core tick, interrupt and port integration block
`ifndef CORE_TICK_IRQ_CFG_SVH
`define CORE_TICK_IRQ_CFG_SVH
// Register byte addresses
`define A_TCTRL     8'h00
`define A_TRLD      8'h04
`define A_TCUR      8'h08
`define A_TCAL      8'h0c
`define A_PEND      8'h10
`define A_ENA       8'h14
`define A_PRIO0     8'h18
`define A_PRIO_LAST 8'h34
`define A_VECTOR_TABLE_OFFSET      8'h38
`define A_VECT      8'h3c
`define A_PRIV      8'h40
`define A_CFG       8'h44
`define A_ROM       8'h48
`define A_NMI       8'h4c
`define A_SADR      8'h50
`define A_SWD       8'h54
`define A_SCMD      8'h58
`define A_SRD       8'h5c
`define A_SSTA      8'h60
// Tick timer fields and timing
`define TC_EN       0
`define TC_INT      1
`define TC_CLK      2
`define TC_FLAG     16
`define TICK_W      24
`define TICK_ONE    24'h00_0001
`define TICK_DIV    16
`define TICK_LAST   4'(`TICK_DIV - 1)
// Interrupt controller
`define NUM_IRQ     32
`define PRIO_W      2
`define PRIO_LSB    6
`define PRIO_LOW    2'h3
`define VEC_BASE    8'h10
`define WAKE_LINES  34
`define VECTOR_TABLE_OFFSET_MASK   32'hffff_ff80
`define NMI_SEL     0
`define NMI_PEND    1
`define PRIV_USER   0
// Fixed build configuration and its read-back fields
`define ENDIAN_SEL  1'b0
`define CLK_GATING  1'b1
`define RESET_ALL   1'b0
`define DBG_PROTO   1'b0
`define MULTIDROP   1'b0
`define ROM_BASE    32'hf000_2003
`define CF_ENDIAN   0
`define CF_ACG      1
`define CF_RAR      2
`define CF_PROTO    3
`define CF_MDROP    4
`define CF_USER     5
`define CF_VECTOR_TABLE_OFFSET     6
`define CF_IOP      7
`define CF_NIRQ     8
`define CF_NWAKE    16
// System port command and status
`define SC_GO       0
`define SC_WR       1
`define SS_BUSY     0
`define SS_ERR      1
`define HT_IDLE     2'h0
`define HT_NONSEQ   2'h2
`define HS_WORD     3'h2
// Bus responses and I/O port addresses
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
`define IOP_DOUT    2'h0
`define IOP_DIR     2'h1
`define IOP_PINS    2'h2
`endif

// ### include/core_tick_irq_pkg.sv
// Types of the core tick, interrupt and port integration block
package core_tick_irq_pkg;
	typedef enum logic [1:0] {
		SYS_IDLE = 2'h0,
		SYS_ADDR = 2'h1,
		SYS_DATA = 2'h3
	} sys_state_type;
endpackage

// ### verilog/core_tick_irq_integration.sv
// Core integration: tick timer, interrupt controller, system and I/O ports
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "core_tick_irq_cfg.svh"
module core_tick_irq_integration (
	// Clock and reset
	input  wire logic                    MCLK,
	input  wire logic                    RESET_N,
	// AXI4-Lite register slave
	input  wire logic [7:0]              AWADDR,
	input  wire logic                    AWVALID,
	output logic                         AWREADY,
	input  wire logic [31:0]             WDATA,
	input  wire logic [3:0]              WSTRB,
	input  wire logic                    WVALID,
	output logic                         WREADY,
	output logic [1:0]                   BRESP,
	output logic                         BVALID,
	input  wire logic                    BREADY,
	input  wire logic [7:0]              ARADDR,
	input  wire logic                    ARVALID,
	output logic                         ARREADY,
	output logic [31:0]                  RDATA,
	output logic [1:0]                   RRESP,
	output logic                         RVALID,
	input  wire logic                    RREADY,
	// Interrupt sources and requests
	input  wire logic [`NUM_IRQ-1:0]     IRQ_IN,
	input  wire logic                    NMI_N,
	output logic                         IRQ_OUT,
	output logic                         NMI_REQ,
	output logic [`WAKE_LINES-1:0]       WAKEUP,
	output logic                         USER_MODE,
	// AHB-Lite system port
	output logic [31:0]                  HADDR,
	output logic [1:0]                   HTRANS,
	output logic                         HWRITE,
	output logic [2:0]                   HSIZE,
	output logic [31:0]                  HWDATA,
	input  wire logic [31:0]             HRDATA,
	input  wire logic                    HREADY,
	input  wire logic                    HRESP,
	// Single-cycle I/O port
	input  wire logic                    IOP_SEL,
	input  wire logic                    IOP_WRITE,
	input  wire logic [1:0]              IOP_ADDR,
	input  wire logic [31:0]             IOP_WDATA,
	output logic [31:0]                  IOP_RDATA,
	// Fast GPIO pins
	input  wire logic [31:0]             GPIO_IN,
	output logic [31:0]                  GPIO_OUT,
	output logic [31:0]                  GPIO_OE
);

	// Byte strobes to a bit mask
	function automatic logic [31:0] smask(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	logic                      awready_r;
	logic                      wready_r;
	logic                      bvalid_r;
	logic [1:0]                bresp_r;
	logic                      arready_r;
	logic                      rvalid_r;
	logic [1:0]                rresp_r;
	logic [31:0]               rdata_r;
	logic [7:0]                waddr_r;
	logic [7:0]                raddr_r;
	logic [31:0]               wdata_r;
	logic [3:0]                wstrb_r;
	logic                      wr_do;
	logic                      rd_do;
	logic                      wr_ok;
	logic [31:0]               wm;
	logic [31:0]               wmerge_rld;
	logic [31:0]               rd_data;
	logic                      rd_ok;
	logic [2:0]                wpi;
	logic [2:0]                rpi;
	logic                      wr_prio;
	logic                      rd_prio;
	logic                      ten_r;
	logic                      tint_r;
	logic                      clksel_r;
	logic                      flag_r;
	logic [`TICK_W-1:0]        rld_r;
	logic [`TICK_W-1:0]        cur_r;
	logic [3:0]                div_r;
	logic                      tick_step;
	logic                      flag_clr;
	logic [`NUM_IRQ-1:0]       pend_r;
	logic [`NUM_IRQ-1:0]       ena_r;
	logic [`NUM_IRQ-1:0]       act;
	logic [`PRIO_W-1:0]        prio_r [`NUM_IRQ];
	logic                      best_found;
	logic [4:0]                best_idx;
	logic [`PRIO_W-1:0]        best_prio;
	logic [7:0]                vect_r;
	logic [31:0]               vector_table_offset_r;
	logic                      user_r;
	logic                      nmi_sel_r;
	logic                      nmi_pend_r;
	logic                      nsync1_r;
	logic                      nsync2_r;
	logic                      nmi_lvl;
	logic                      nmi_lvl_d_r;
	logic                      nmi_req_r;
	logic                      irq_r;
	logic [`WAKE_LINES-1:0]    wake_r;
	logic [31:0]               sadr_r;
	logic [31:0]               swd_r;
	logic [31:0]               srd_r;
	logic                      swr_r;
	logic                      sbusy_r;
	logic                      serr_r;
	logic                      sys_go;
	core_tick_irq_pkg::sys_state_type st_r;
	logic [31:0]               haddr_r;
	logic [1:0]                htrans_r;
	logic                      hwrite_r;
	logic [2:0]                hsize_r;
	logic [31:0]               hwdata_r;
	logic [31:0]               gout_r;
	logic [31:0]               goe_r;
	logic [31:0]               gin1_r;
	logic [31:0]               gin2_r;
	logic [31:0]               iop_rd_r;

	// Write and read strobes of the register file
	assign wr_do = !awready_r && !wready_r && !bvalid_r;
	assign rd_do = !arready_r && !rvalid_r;
	assign wm = smask(wstrb_r);
	assign wmerge_rld = ({8'h00, rld_r} & ~wm) | (wdata_r & wm);
	assign wr_prio = waddr_r >= `A_PRIO0 && waddr_r <= `A_PRIO_LAST;
	assign rd_prio = raddr_r >= `A_PRIO0 && raddr_r <= `A_PRIO_LAST;
	assign wpi = 3'((waddr_r - `A_PRIO0) >> 2);
	assign rpi = 3'((raddr_r - `A_PRIO0) >> 2);

	// Write channel: address and data taken in either order
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= `RESP_OK;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (AWVALID && awready_r) begin
				waddr_r   <= {AWADDR[7:2], 2'h0};
				awready_r <= 1'b0;
			end
			if (WVALID && wready_r) begin
				wdata_r  <= WDATA;
				wstrb_r  <= WSTRB;
				wready_r <= 1'b0;
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok ? `RESP_OK : `RESP_ERR;
			end
			if (bvalid_r && BREADY) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Writable addresses
	always_comb begin
		case (waddr_r)
			`A_TCTRL, `A_TRLD, `A_TCUR, `A_PEND, `A_ENA, `A_VECTOR_TABLE_OFFSET, `A_PRIV, `A_NMI,
			`A_SADR, `A_SWD, `A_SCMD: wr_ok = 1'b1;
			default: wr_ok = wr_prio;
		endcase
	end

	// Read channel: data one cycle after the address is taken
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= `RESP_OK;
			rdata_r   <= 32'h0000_0000;
			raddr_r   <= 8'h00;
		end else begin
			if (ARVALID && arready_r) begin
				raddr_r   <= {ARADDR[7:2], 2'h0};
				arready_r <= 1'b0;
			end
			if (rd_do) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_data;
				rresp_r  <= rd_ok ? `RESP_OK : `RESP_ERR;
			end
			if (rvalid_r && RREADY) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// Read multiplexer; unmapped addresses answer zero with an error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (raddr_r)
			`A_TCTRL: begin
				rd_data[`TC_EN]   = ten_r;
				rd_data[`TC_INT]  = tint_r;
				rd_data[`TC_CLK]  = clksel_r;
				rd_data[`TC_FLAG] = flag_r;
			end
			`A_TRLD: rd_data = {8'h00, rld_r};
			`A_TCUR: rd_data = {8'h00, cur_r};
			`A_TCAL: rd_data = 32'h0000_0000;
			`A_PEND: rd_data = pend_r;
			`A_ENA:  rd_data = ena_r;
			`A_VECTOR_TABLE_OFFSET: rd_data = vector_table_offset_r;
			`A_VECT: rd_data = {24'h00_0000, vect_r};
			`A_PRIV: rd_data[`PRIV_USER] = user_r;
			`A_CFG: begin
				rd_data[`CF_ENDIAN]   = `ENDIAN_SEL;
				rd_data[`CF_ACG]      = `CLK_GATING;
				rd_data[`CF_RAR]      = `RESET_ALL;
				rd_data[`CF_PROTO]    = `DBG_PROTO;
				rd_data[`CF_MDROP]    = `MULTIDROP;
				rd_data[`CF_USER]     = 1'b1;
				rd_data[`CF_VECTOR_TABLE_OFFSET]     = 1'b1;
				rd_data[`CF_IOP]      = 1'b1;
				rd_data[`CF_NIRQ+:8]  = 8'(`NUM_IRQ);
				rd_data[`CF_NWAKE+:8] = 8'(`WAKE_LINES);
			end
			`A_ROM: rd_data = `ROM_BASE;
			`A_NMI: begin
				rd_data[`NMI_SEL]  = nmi_sel_r;
				rd_data[`NMI_PEND] = nmi_pend_r;
			end
			`A_SADR: rd_data = sadr_r;
			`A_SWD:  rd_data = swd_r;
			`A_SCMD: rd_data[`SC_WR] = swr_r;
			`A_SRD:  rd_data = srd_r;
			`A_SSTA: begin
				rd_data[`SS_BUSY] = sbusy_r;
				rd_data[`SS_ERR]  = serr_r;
			end
			default: begin
				if (rd_prio) begin
					for (int j = 0; j < 4; j++) begin
						rd_data[8*j+`PRIO_LSB +: `PRIO_W] = prio_r[{rpi, 2'(j)}];
					end
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// Divide-by-16 enable and tick step selection
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			div_r <= 4'h0;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end
	assign tick_step = ten_r && (clksel_r || div_r == `TICK_LAST);

	// Tick control and reload registers
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			ten_r    <= 1'b0;
			tint_r   <= 1'b0;
			clksel_r <= 1'b0;
			rld_r    <= '0;
		end else if (wr_do) begin
			if (waddr_r == `A_TCTRL && wstrb_r[0]) begin
				ten_r    <= wdata_r[`TC_EN];
				tint_r   <= wdata_r[`TC_INT];
				clksel_r <= wdata_r[`TC_CLK];
			end
			if (waddr_r == `A_TRLD) begin
				rld_r <= wmerge_rld[`TICK_W-1:0];
			end
		end
	end

	// Down-counter: reload at zero, flag when zero is reached
	assign flag_clr = (rd_do && raddr_r == `A_TCTRL) || (wr_do && waddr_r == `A_TCUR);
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			cur_r  <= '0;
			flag_r <= 1'b0;
		end else begin
			if (wr_do && waddr_r == `A_TCUR) begin
				cur_r <= '0;
			end else if (tick_step) begin
				cur_r <= (cur_r == '0) ? rld_r : cur_r - `TICK_ONE;
			end
			flag_r <= (tick_step && cur_r == `TICK_ONE) || (flag_r && !flag_clr);
		end
	end

	// Pending and enable bits; a new request wins over a clear
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			pend_r <= '0;
			ena_r  <= '0;
		end else begin
			pend_r <= IRQ_IN | (pend_r & ~((wr_do && waddr_r == `A_PEND) ? (wdata_r & wm) : '0));
			if (wr_do && waddr_r == `A_ENA) begin
				ena_r <= (ena_r & ~wm) | (wdata_r & wm);
			end
		end
	end

	// Two-bit priority fields in the upper bits of each byte
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < `NUM_IRQ; i++) begin
				prio_r[i] <= '0;
			end
		end else if (wr_do && wr_prio) begin
			for (int j = 0; j < 4; j++) begin
				if (wstrb_r[j]) begin
					prio_r[{wpi, 2'(j)}] <= wdata_r[8*j+`PRIO_LSB +: `PRIO_W];
				end
			end
		end
	end

	// Highest-priority active source; lowest number wins a tie
	assign act = pend_r & ena_r;
	always_comb begin
		best_found = 1'b0;
		best_idx   = 5'h00;
		best_prio  = `PRIO_LOW;
		for (int i = 0; i < `NUM_IRQ; i++) begin
			if (act[i] && (!best_found || prio_r[i] < best_prio)) begin
				best_found = 1'b1;
				best_idx   = 5'(i);
				best_prio  = prio_r[i];
			end
		end
	end

	// Vector of the winner, table offset and operating level
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			vect_r <= 8'h00;
			vector_table_offset_r <= 32'h0000_0000;
			user_r <= 1'b0;
		end else begin
			vect_r <= best_found ? 8'(best_idx) + `VEC_BASE : 8'h00;
			if (wr_do && waddr_r == `A_VECTOR_TABLE_OFFSET) begin
				vector_table_offset_r <= ((vector_table_offset_r & ~wm) | (wdata_r & wm)) & `VECTOR_TABLE_OFFSET_MASK;
			end
			if (wr_do && waddr_r == `A_PRIV && wstrb_r[0]) begin
				user_r <= wdata_r[`PRIV_USER];
			end
		end
	end

	// NMI pin synchroniser
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			nsync1_r <= 1'b1;
			nsync2_r <= 1'b1;
		end else begin
			nsync1_r <= NMI_N;
			nsync2_r <= nsync1_r;
		end
	end

	// NMI request only while the pin function is selected
	assign nmi_lvl = nmi_sel_r && !nsync2_r;
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			nmi_sel_r   <= 1'b0;
			nmi_pend_r  <= 1'b0;
			nmi_lvl_d_r <= 1'b0;
			nmi_req_r   <= 1'b0;
		end else begin
			nmi_lvl_d_r <= nmi_lvl;
			nmi_req_r   <= nmi_lvl;
			if (wr_do && waddr_r == `A_NMI && wstrb_r[0]) begin
				nmi_sel_r <= wdata_r[`NMI_SEL];
			end
			nmi_pend_r <= (nmi_lvl && !nmi_lvl_d_r) ||
				(nmi_pend_r && !(wr_do && waddr_r == `A_NMI && wstrb_r[0] && wdata_r[`NMI_PEND]));
		end
	end

	// Interrupt output and wakeup lines
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			irq_r  <= 1'b0;
			wake_r <= '0;
		end else begin
			irq_r  <= (|act) || (flag_r && tint_r) || nmi_pend_r;
			wake_r <= {flag_r && tint_r, nmi_pend_r, act};
		end
	end

	// System port command registers
	assign sys_go = wr_do && waddr_r == `A_SCMD && wstrb_r[0] && wdata_r[`SC_GO] &&
		st_r == core_tick_irq_pkg::SYS_IDLE;
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			sadr_r <= 32'h0000_0000;
			swd_r  <= 32'h0000_0000;
			swr_r  <= 1'b0;
		end else if (wr_do) begin
			if (waddr_r == `A_SADR) begin
				sadr_r <= (sadr_r & ~wm) | (wdata_r & wm);
			end
			if (waddr_r == `A_SWD) begin
				swd_r <= (swd_r & ~wm) | (wdata_r & wm);
			end
			if (waddr_r == `A_SCMD && wstrb_r[0]) begin
				swr_r <= wdata_r[`SC_WR];
			end
		end
	end

	// AHB-Lite master: address phase, then data phase
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			st_r     <= core_tick_irq_pkg::SYS_IDLE;
			haddr_r  <= 32'h0000_0000;
			htrans_r <= `HT_IDLE;
			hwrite_r <= 1'b0;
			hsize_r  <= `HS_WORD;
			hwdata_r <= 32'h0000_0000;
			srd_r    <= 32'h0000_0000;
			sbusy_r  <= 1'b0;
			serr_r   <= 1'b0;
		end else begin
			case (st_r)
				core_tick_irq_pkg::SYS_IDLE: begin
					if (sys_go) begin
						haddr_r  <= {sadr_r[31:2], 2'h0};
						hwrite_r <= wdata_r[`SC_WR];
						htrans_r <= `HT_NONSEQ;
						sbusy_r  <= 1'b1;
						serr_r   <= 1'b0;
						st_r     <= core_tick_irq_pkg::SYS_ADDR;
					end
				end
				core_tick_irq_pkg::SYS_ADDR: begin
					if (HREADY) begin
						htrans_r <= `HT_IDLE;
						hwdata_r <= swd_r;
						st_r     <= core_tick_irq_pkg::SYS_DATA;
					end
				end
				core_tick_irq_pkg::SYS_DATA: begin
					if (HREADY) begin
						srd_r   <= HRDATA;
						serr_r  <= HRESP;
						sbusy_r <= 1'b0;
						st_r    <= core_tick_irq_pkg::SYS_IDLE;
					end
				end
				default: st_r <= core_tick_irq_pkg::SYS_IDLE;
			endcase
		end
	end

	// GPIO pin synchroniser
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			gin1_r <= 32'h0000_0000;
			gin2_r <= 32'h0000_0000;
		end else begin
			gin1_r <= GPIO_IN;
			gin2_r <= gin1_r;
		end
	end

	// Single-cycle I/O port to the fast GPIO block
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			gout_r   <= 32'h0000_0000;
			goe_r    <= 32'h0000_0000;
			iop_rd_r <= 32'h0000_0000;
		end else if (IOP_SEL) begin
			if (IOP_WRITE) begin
				if (IOP_ADDR == `IOP_DOUT) begin
					gout_r <= IOP_WDATA;
				end
				if (IOP_ADDR == `IOP_DIR) begin
					goe_r <= IOP_WDATA;
				end
			end else begin
				case (IOP_ADDR)
					`IOP_DOUT: iop_rd_r <= gout_r;
					`IOP_DIR:  iop_rd_r <= goe_r;
					`IOP_PINS: iop_rd_r <= gin2_r;
					default:   iop_rd_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Outputs straight from flip-flops
	assign AWREADY   = awready_r;
	assign WREADY    = wready_r;
	assign BVALID    = bvalid_r;
	assign BRESP     = bresp_r;
	assign ARREADY   = arready_r;
	assign RVALID    = rvalid_r;
	assign RRESP     = rresp_r;
	assign RDATA     = rdata_r;
	assign IRQ_OUT   = irq_r;
	assign NMI_REQ   = nmi_req_r;
	assign WAKEUP    = wake_r;
	assign USER_MODE = user_r;
	assign HADDR     = haddr_r;
	assign HTRANS    = htrans_r;
	assign HWRITE    = hwrite_r;
	assign HSIZE     = hsize_r;
	assign HWDATA    = hwdata_r;
	assign IOP_RDATA = iop_rd_r;
	assign GPIO_OUT  = gout_r;
	assign GPIO_OE   = goe_r;

endmodule

// ### sim/core_tick_irq_sva.sv
// Port-level assertions for the core tick, interrupt and port block
`timescale 1ns/1ns
`include "core_tick_irq_cfg.svh"
module core_tick_irq_sva (
	// Clock and reset
	input logic        MCLK,
	input logic        RESET_N,
	// Register bus handshakes
	input logic        AWVALID,
	input logic        AWREADY,
	input logic        WVALID,
	input logic        WREADY,
	input logic        BVALID,
	input logic        ARVALID,
	input logic        ARREADY,
	input logic        RVALID,
	// Interrupts
	input logic        NMI_N,
	input logic        NMI_REQ,
	input logic        IRQ_OUT,
	input logic [33:0] WAKEUP,
	// System port
	input logic [31:0] HADDR,
	input logic [1:0]  HTRANS,
	input logic [2:0]  HSIZE,
	input logic        HREADY,
	// I/O port and pins
	input logic        IOP_SEL,
	input logic        IOP_WRITE,
	input logic [1:0]  IOP_ADDR,
	input logic [31:0] IOP_WDATA,
	input logic [31:0] IOP_RDATA,
	input logic [31:0] GPIO_OUT,
	input logic [31:0] GPIO_OE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// Bus answers come promptly
	chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
		else $error("write response late");
	chk_read_answer: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
		else $error("read response late");
	// Interrupt outputs agree and follow the pin
	chk_irq_wake: assert property (IRQ_OUT == (|WAKEUP))
		else $error("interrupt and wakeup disagree");
	chk_nmi_pin: assert property (NMI_REQ |-> !$past(NMI_N, 3))
		else $error("nmi request without low pin");
	// System port keeps the address phase and word size
	chk_ahb_hold: assert property (HTRANS == `HT_NONSEQ && !HREADY |=> HTRANS == `HT_NONSEQ && $stable(HADDR))
		else $error("address phase dropped");
	chk_ahb_word: assert property (HSIZE == `HS_WORD)
		else $error("transfer not word");
	chk_ahb_next: assert property (HTRANS == `HT_NONSEQ && HREADY |=> HTRANS == `HT_IDLE && $stable(HADDR))
		else $error("address phase not ended");
	// I/O port accesses complete in one cycle
	chk_iop_dout: assert property (IOP_SEL && IOP_WRITE && IOP_ADDR == `IOP_DOUT |=> GPIO_OUT == $past(IOP_WDATA))
		else $error("output write late");
	chk_iop_dir: assert property (IOP_SEL && IOP_WRITE && IOP_ADDR == `IOP_DIR |=> GPIO_OE == $past(IOP_WDATA))
		else $error("direction write late");
	chk_iop_spare: assert property (IOP_SEL && !IOP_WRITE && IOP_ADDR == 2'h3 |=> IOP_RDATA == 32'h0)
		else $error("spare read not zero");
endmodule
bind core_tick_irq_integration core_tick_irq_sva chk (.MCLK, .RESET_N, .AWVALID, .AWREADY, .WVALID, .WREADY,
	.BVALID, .ARVALID, .ARREADY, .RVALID, .NMI_N, .NMI_REQ, .IRQ_OUT, .WAKEUP, .HADDR, .HTRANS, .HSIZE,
	.HREADY, .IOP_SEL, .IOP_WRITE, .IOP_ADDR, .IOP_WDATA, .IOP_RDATA, .GPIO_OUT, .GPIO_OE);

// ### sim/ahb_gpio_model.sv
// Far side: AHB-Lite memory with one wait state, and the fast GPIO pins
`timescale 1ns/1ns
module ahb_gpio_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hready,
	output logic             hresp,
	// Pins
	input  wire logic [31:0] gpio_out,
	input  wire logic [31:0] gpio_oe,
	output logic [31:0]      gpio_in
);
	logic [31:0] mem [16];
	logic [31:0] a_r;
	logic        ph_r;
	logic        w_r;
	// Region 0xe answers with the two-cycle error response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph_r <= 1'b0;
			hready <= 1'b1;
			hresp <= 1'b0;
		end else if (htrans == 2'h2 && hready) begin
			a_r <= haddr;
			w_r <= hwrite;
			ph_r <= 1'b1;
			hready <= 1'b0;
			hresp <= haddr[31:28] == 4'he;
		end else if (ph_r && !hready) begin
			hready <= 1'b1;
		end else if (ph_r) begin
			ph_r <= 1'b0;
			hresp <= 1'b0;
			if (w_r && !hresp) mem[a_r[5:2]] <= hwdata;
		end
	end
	// Read data is valid only in the last data cycle
	assign hrdata = (ph_r && hready) ? mem[a_r[5:2]] : ~mem[a_r[5:2]];
	// Undriven pins float to a fixed pattern
	assign gpio_in = (gpio_out & gpio_oe) | (~gpio_oe & 32'h0f0f_0f0f);
endmodule

// ### sim/testbench.sv
// Self-checking bench for the core tick, interrupt and port block
`timescale 1ns/1ns
`include "core_tick_irq_cfg.svh"
module testbench;
	logic        MCLK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, NMI_N, HREADY, HRESP, IOP_SEL;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_OUT, NMI_REQ, USER_MODE, HWRITE, IOP_WRITE;
	logic [1:0]  BRESP, RRESP, HTRANS, IOP_ADDR, rr, br;
	logic [2:0]  HSIZE;
	logic [3:0]  WSTRB;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, IRQ_IN, HADDR, HWDATA, HRDATA, IOP_WDATA, IOP_RDATA, GPIO_IN, GPIO_OUT, GPIO_OE;
	logic [33:0] WAKEUP;
	logic [31:0] d, v, t1, t_rd, cyc;
	int          fails, samples_checked;
	core_tick_irq_integration uut (.MCLK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
		.WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.IRQ_IN, .NMI_N, .IRQ_OUT, .NMI_REQ, .WAKEUP, .USER_MODE, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
		.HRDATA, .HREADY, .HRESP, .IOP_SEL, .IOP_WRITE, .IOP_ADDR, .IOP_WDATA, .IOP_RDATA, .GPIO_IN,
		.GPIO_OUT, .GPIO_OE);
	ahb_gpio_model far (.clk(MCLK), .rst_n(RESET_N), .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE),
		.hwdata(HWDATA), .hrdata(HRDATA), .hready(HREADY), .hresp(HRESP), .gpio_out(GPIO_OUT),
		.gpio_oe(GPIO_OE), .gpio_in(GPIO_IN));
	// Clock and cycle count
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	always @(posedge MCLK) cyc <= RESET_N ? cyc + 32'h1 : 32'h0;
	// Compare one value
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Register write; response kept in br
	task wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= x;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		br = BRESP;
		BREADY <= 1'b0;
	endtask
	// Register read; notes the cycle the address was taken
	task rd(input logic [7:0] a);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (ARVALID && ARREADY) begin
				ARVALID <= 1'b0;
				t_rd = cyc;
			end
		end while (RVALID !== 1'b1);
		d = RDATA;
		rr = RRESP;
		RREADY <= 1'b0;
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
	endtask
	// One I/O port access; caller drops the select
	task io(input logic w, input logic [1:0] a, input logic [31:0] x);
		@(posedge MCLK);
		IOP_SEL <= 1'b1;
		IOP_WRITE <= w;
		IOP_ADDR <= a;
		IOP_WDATA <= x;
	endtask
	task end_of_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge MCLK);
		fails++;
		end_of_test();
	end
	// Main sequence
	initial begin
		{RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, IOP_SEL, IOP_WRITE, IOP_ADDR} = 0;
		{AWADDR, ARADDR, WDATA, IRQ_IN, IOP_WDATA} = 0;
		NMI_N = 1'b1;
		WSTRB = 4'hf;
		repeat (6) @(posedge MCLK);
		RESET_N <= 1'b1;
		rdc("config", `A_CFG, 32'h0022_20e2);
		rdc("rom base", `A_ROM, 32'hf000_2003);
		rdc("calib", `A_TCAL, 32'h0);
		rdc("unmapped", 8'h7c, 32'h0);
		chk("rresp", `RESP_ERR, rr);
		wr(8'h7c, 32'h1);
		chk("bresp", `RESP_ERR, br);
		// Tick rate for both clock selects over a known span
		wr(`A_TRLD, 32'h00_ffff);
		wr(`A_TCTRL, 32'h5);
		wr(`A_TCUR, 32'h0);
		for (int s = 0; s < 2; s++) begin
			wr(`A_TCTRL, s ? 32'h5 : 32'h1);
			rd(`A_TCUR);
			t1 = t_rd;
			v = d;
			while (cyc < t1 + 158) @(posedge MCLK);
			rd(`A_TCUR);
			chk("tick", v - (s ? t_rd - t1 : (t_rd - t1) / 16), d);
		end
		// Count flag: masked, raised, cleared by read
		wr(`A_TRLD, 32'h3);
		wr(`A_TCUR, 32'h0);
		wr(`A_TCTRL, 32'h5);
		repeat (8) @(posedge MCLK);
		@(negedge MCLK) chk("irq masked", 0, IRQ_OUT);
		wr(`A_TCTRL, 32'h6);
		@(negedge MCLK) chk("irq tick", 1, IRQ_OUT);
		rdc("flag set", `A_TCTRL, 32'h0001_0006);
		rdc("flag clr", `A_TCTRL, 32'h6);
		@(negedge MCLK) chk("irq off", 0, IRQ_OUT);
		// Priorities and vector numbers
		wr(`A_PRIO0, 32'hffff_ffff);
		rdc("prio", `A_PRIO0, 32'hc0c0_c0c0);
		wr(8'h1c, 32'h0000_c000);
		wr(`A_PRIO_LAST, 32'h0);
		@(posedge MCLK) IRQ_IN <= 32'h8000_0020;
		@(posedge MCLK) IRQ_IN <= 32'h0;
		rdc("pend", `A_PEND, 32'h8000_0020);
		@(negedge MCLK) chk("irq disabled", 0, IRQ_OUT);
		wr(`A_ENA, 32'h8000_0020);
		rdc("best vector", `A_VECT, 32'd47);
		@(negedge MCLK) chk("irq pend", 1, IRQ_OUT);
		chk("wake", 32'h8000_0020, WAKEUP[31:0]);
		wr(`A_PEND, 32'h8000_0000);
		rdc("next vector", `A_VECT, 32'd21);
		wr(`A_PEND, 32'h20);
		@(negedge MCLK) chk("irq cleared", 0, IRQ_OUT);
		// Pin gives a request only with its function selected
		@(posedge MCLK) NMI_N <= 1'b0;
		repeat (6) @(posedge MCLK);
		@(negedge MCLK) chk("nmi unselected", 0, NMI_REQ);
		wr(`A_NMI, 32'h1);
		repeat (4) @(posedge MCLK);
		@(negedge MCLK) chk("nmi", 1, NMI_REQ);
		rdc("nmi pend", `A_NMI, 32'h3);
		wr(`A_NMI, 32'h3);
		NMI_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		@(negedge MCLK) chk("nmi gone", 0, NMI_REQ);
		// Operating level and vector table offset
		wr(`A_PRIV, 32'h1);
		@(negedge MCLK) chk("user", 1, USER_MODE);
		wr(`A_VECTOR_TABLE_OFFSET, 32'hffff_ffff);
		rdc("vector_table_offset", `A_VECTOR_TABLE_OFFSET, 32'hffff_ff80);
		// System port write, read back, error
		wr(`A_SADR, 32'h2000_0010);
		wr(`A_SWD, 32'h1122_3344);
		wr(`A_SCMD, 32'h3);
		do rd(`A_SSTA); while (d[0] !== 1'b0);
		wr(`A_SCMD, 32'h1);
		do rd(`A_SSTA); while (d[0] !== 1'b0);
		rdc("sys read", `A_SRD, 32'h1122_3344);
		wr(`A_SADR, 32'he000_0000);
		wr(`A_SCMD, 32'h1);
		do rd(`A_SSTA); while (d[0] !== 1'b0);
		chk("sys error", 32'h2, d);
		// I/O port back-to-back writes, pin read, spare read
		io(1'b1, `IOP_DIR, 32'hffff_0000);
		io(1'b1, `IOP_DOUT, 32'ha5a5_a5a5);
		@(posedge MCLK) IOP_SEL <= 1'b0;
		@(negedge MCLK) chk("gpio out", 32'ha5a5_a5a5, GPIO_OUT);
		chk("gpio oe", 32'hffff_0000, GPIO_OE);
		repeat (3) @(posedge MCLK);
		io(1'b0, `IOP_PINS, 32'h0);
		@(posedge MCLK) IOP_SEL <= 1'b0;
		@(negedge MCLK) chk("pins", 32'ha5a5_0f0f, IOP_RDATA);
		io(1'b0, 2'h3, 32'h0);
		@(posedge MCLK) IOP_SEL <= 1'b0;
		@(negedge MCLK) chk("spare", 32'h0, IOP_RDATA);
		end_of_test();
	end
endmodule
